// [acid_defs.vh]
// Purpose: Register map and field layout of the crossbar and integer delay block
// Assumes: Byte-wide paged registers with 12-bit addresses
// Notes:   Definitions only
`ifndef ACID_DEFS_VH
`define ACID_DEFS_VH

// =========================================================
// Register offsets
`define ACID_ADDR_COARSE_PAGE   12'h018
`define ACID_ADDR_FILT_PAGE     12'h01E
`define ACID_ADDR_PROFILE_0     12'hB01
`define ACID_ADDR_PROFILE_1     12'hB02
`define ACID_ADDR_PROFILE_2     12'hB03
`define ACID_ADDR_PROFILE_3     12'hB04
`define ACID_ADDR_PROFILE_CTRL  12'hB05
`define ACID_ADDR_SRC_SELECT    12'hB12
`define ACID_ADDR_DELAY_ENABLE  12'hB14
`define ACID_ADDR_AUX_ROUTE     12'hB20

// =========================================================
// Field positions
`define ACID_CTRL_PIN_EN_BIT    4
`define ACID_CTRL_SEL_MSB       1
`define ACID_CTRL_SEL_LSB       0
`define ACID_PAGE_PAIR01        2'h1
`define ACID_PAGE_PAIR23        2'h2

// =========================================================
// Aux route codes
`define ACID_ROUTE_BYPASS       2'h0
`define ACID_ROUTE_FILTER       2'h1
`define ACID_ROUTE_DELAY        2'h2

// =========================================================
// Reset values and timing
`define ACID_RST_BYTE           8'h00
`define ACID_RST_PROFILE        4'h8
`define ACID_DELAY_TAPS         16

`endif

// [acid_top.v]
// Purpose: Input crossbar, aux stage route and 16-tap integer delay per logical output
// Assumes: One sample per clk_sys edge; FIR lives outside and returns on fir_data
// Notes:   Registers reached over a plain byte register port
//
// Behaviour
// - Crossbar maps two or four physical converters onto four logical outputs.
// - Each logical output takes any converter and feeds the filter input.
// - With aux stage bypassed, logical outputs go straight to path crossbar.
// - Filter page field 01 selects logical 0/1, 10 selects logical 2/3.
// - Source select bits 1:0 feed even logical, bits 3:2 odd logical.
// - Two-converter variant uses its own source code table per logical output.
// - Four-converter variant uses its own source code table per logical output.
// - Several logical outputs may pick the same converter simultaneously.
// - Filter precedes delay; either output may feed the path crossbar.
// - Each delay is a 16-tap line with a 16-to-1 tap selector.
// - Delay register writes go to blocks chosen by coarse path page.
// - Delay block acts only while its enable register is set.
// - Profile 0 sets relative shift from minus eight to plus seven.
// - Profile value zero means a shift of minus eight samples.
// - Four profiles exist; control register picks the active one.
// - Pin control enable takes active profile from pins.
// - Otherwise the profile select field names the active profile.
`timescale 1ns/100ps
`include "acid_defs.vh"

module acid_top #(
    parameter SAMPLE_W = 16,                     // Sample width
    parameter NUM_CONV = 4                       // Physical converters, 2 or 4
) (
    input  wire                  clk_sys,        // Sample clock
    input  wire                  nrst,           // Synchronous reset, active low
    input  wire [4*SAMPLE_W-1:0] conv_data,      // Physical converter samples
    input  wire [4*SAMPLE_W-1:0] fir_data,       // Returned FIR outputs
    input  wire [1:0]            delay_pin_sel,  // Profile select pins
    input  wire [11:0]           reg_addr,       // Register address
    input  wire [7:0]            reg_wdata,      // Register write data
    input  wire                  reg_wr,         // Write strobe
    input  wire                  reg_rd,         // Read strobe
    output reg  [7:0]            reg_rdata,      // Read data
    output reg  [4*SAMPLE_W-1:0] fir_in_data,    // Logical outputs to FIR
    output reg  [4*SAMPLE_W-1:0] path_out_data   // Data to path crossbar
);

    // =========================================================
    // Source lookup
    // four-converter and two-converter codes
    function [1:0] acid_src;
        input [1:0] logical;
        input [1:0] code;
        reg   [1:0] four;
        begin
            four = 2'h0;
            case (logical)
                // Logical 0: codes pick converters 0, 2, 1, 3
                2'h0: four = {code[0], code[1]};
                // Logical 1: codes pick converters 2, 1, 3, 0
                2'h1: begin
                    case (code)
                        2'h0:    four = 2'h2;
                        2'h1:    four = 2'h1;
                        2'h2:    four = 2'h3;
                        default: four = 2'h0;
                    endcase
                end
                // Logical 2: codes pick converters 1, 3, 0, 2
                2'h2: begin
                    case (code)
                        2'h0:    four = 2'h1;
                        2'h1:    four = 2'h3;
                        2'h2:    four = 2'h0;
                        default: four = 2'h2;
                    endcase
                end
                // Logical 3: codes pick converters 3, 0, 2, 1
                default: begin
                    case (code)
                        2'h0:    four = 2'h3;
                        2'h1:    four = 2'h0;
                        2'h2:    four = 2'h2;
                        default: four = 2'h1;
                    endcase
                end
            endcase
            if (NUM_CONV == 4) begin
                acid_src = four;
            end else begin
                // Two-converter variant: code bit 1 alone picks the converter
                case (logical)
                    2'h0:    acid_src = {1'b0, code[1]};
                    2'h1:    acid_src = {1'b0, ~code[1]};
                    2'h2:    acid_src = {1'b0, ~code[1]};
                    default: acid_src = {1'b0, code[1]};
                endcase
            end
        end
    endfunction

    // =========================================================
    // Registers
    reg [7:0]          coarse_page_q;            // Delay block page mask
    reg [7:0]          filt_page_q;              // Filter pair page
    reg [1:0]          src_code_q [0:3];         // Source code per logical
    reg [3:0]          profile_q  [0:15];        // Profile 4*blk+n
    reg [7:0]          prof_ctrl_q [0:3];        // Profile control per block
    reg [3:0]          delay_en_q;               // Enable per block
    reg [1:0]          route_q;                  // Aux stage route
    reg [1:0]          pin_s1_q;                 // Pin sync stage 1
    reg [1:0]          pin_s2_q;                 // Pin sync stage 2
    reg [1:0]          pin_s3_q;                 // Pin sync stage 3
    reg [1:0]          pin_sel_q;                // Accepted pin select
    reg [SAMPLE_W-1:0] tap_q [0:4*`ACID_DELAY_TAPS-1]; // Delay lines
    reg [1:0]          rd_blk;                   // Block shown on read
    wire [4*SAMPLE_W-1:0] del_flat;              // Selected delay tap per lane
    // Loop indices, one set per process so none has two drivers
    integer            i_w;
    integer            i_x;
    integer            i_t;
    integer            j_t;
    integer            i_o;
    genvar             g;

    // Lowest paged block answers reads
    always @* begin
        rd_blk = coarse_page_q[0] ? 2'h0 : coarse_page_q[1] ? 2'h1 : coarse_page_q[2] ? 2'h2 :
                 coarse_page_q[3] ? 2'h3 : 2'h0;
    end

    // =========================================================
    // Register writes
    always @(posedge clk_sys) begin
        if (!nrst) begin
            coarse_page_q <= `ACID_RST_BYTE;
            filt_page_q   <= `ACID_RST_BYTE;
            delay_en_q    <= 4'h0;
            route_q       <= `ACID_ROUTE_BYPASS;
            for (i_w = 0; i_w < 4; i_w = i_w + 1) begin
                src_code_q[i_w]  <= 2'h0;
                prof_ctrl_q[i_w] <= `ACID_RST_BYTE;
            end
            for (i_w = 0; i_w < 16; i_w = i_w + 1) begin
                profile_q[i_w] <= `ACID_RST_PROFILE;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `ACID_ADDR_COARSE_PAGE: coarse_page_q <= reg_wdata;
                `ACID_ADDR_FILT_PAGE:   filt_page_q   <= reg_wdata;
                `ACID_ADDR_AUX_ROUTE:   route_q       <= reg_wdata[1:0];
                `ACID_ADDR_SRC_SELECT: begin
                    // Page 11 writes both pairs with one access
                    // pair paging
                    if (filt_page_q[0]) begin
                        src_code_q[0] <= reg_wdata[1:0];
                        src_code_q[1] <= reg_wdata[3:2];
                    end
                    if (filt_page_q[1]) begin
                        src_code_q[2] <= reg_wdata[1:0];
                        src_code_q[3] <= reg_wdata[3:2];
                    end
                end
                default: begin
                    for (i_w = 0; i_w < 4; i_w = i_w + 1) begin
                        if (coarse_page_q[i_w]) begin
                            case (reg_addr)
                                `ACID_ADDR_DELAY_ENABLE: delay_en_q[i_w]      <= reg_wdata[0];
                                `ACID_ADDR_PROFILE_CTRL: prof_ctrl_q[i_w]     <= reg_wdata;
                                `ACID_ADDR_PROFILE_0:    profile_q[4*i_w]     <= reg_wdata[3:0];
                                `ACID_ADDR_PROFILE_1:    profile_q[4*i_w + 1] <= reg_wdata[3:0];
                                `ACID_ADDR_PROFILE_2:    profile_q[4*i_w + 2] <= reg_wdata[3:0];
                                `ACID_ADDR_PROFILE_3:    profile_q[4*i_w + 3] <= reg_wdata[3:0];
                                default: ;
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    // =========================================================
    // Register reads, unmapped addresses read zero
    always @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= `ACID_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `ACID_ADDR_COARSE_PAGE:  reg_rdata <= coarse_page_q;
                `ACID_ADDR_FILT_PAGE:    reg_rdata <= filt_page_q;
                `ACID_ADDR_AUX_ROUTE:    reg_rdata <= {6'h00, route_q};
                `ACID_ADDR_SRC_SELECT:   reg_rdata <= filt_page_q[1] && !filt_page_q[0] ?
                                                      {4'h0, src_code_q[3], src_code_q[2]} :
                                                      {4'h0, src_code_q[1], src_code_q[0]};
                // Paged registers read back the lowest selected block only
                `ACID_ADDR_DELAY_ENABLE: reg_rdata <= {7'h00, delay_en_q[rd_blk]};
                `ACID_ADDR_PROFILE_CTRL: reg_rdata <= prof_ctrl_q[rd_blk];
                `ACID_ADDR_PROFILE_0:    reg_rdata <= {4'h0, profile_q[{rd_blk, 2'h0}]};
                `ACID_ADDR_PROFILE_1:    reg_rdata <= {4'h0, profile_q[{rd_blk, 2'h1}]};
                `ACID_ADDR_PROFILE_2:    reg_rdata <= {4'h0, profile_q[{rd_blk, 2'h2}]};
                `ACID_ADDR_PROFILE_3:    reg_rdata <= {4'h0, profile_q[{rd_blk, 2'h3}]};
                default:                 reg_rdata <= `ACID_RST_BYTE;
            endcase
        end
    end

    // =========================================================
    // Profile pins: three flops, accept when stages 2 and 3 agree
    // A pin edge near the clock may settle late; agreement filters that out
    always @(posedge clk_sys) begin
        if (!nrst) begin
            pin_s1_q  <= 2'h0;
            pin_s2_q  <= 2'h0;
            pin_s3_q  <= 2'h0;
            pin_sel_q <= 2'h0;
        end else begin
            pin_s1_q <= delay_pin_sel;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q == pin_s3_q) begin
                pin_sel_q <= pin_s3_q;
            end
        end
    end

    // =========================================================
    // Input crossbar
    // Shared sources are plain fan-out, so no arbitration is needed
    always @(posedge clk_sys) begin
        if (!nrst) begin
            fir_in_data <= {4*SAMPLE_W{1'b0}};
        end else begin
            for (i_x = 0; i_x < 4; i_x = i_x + 1) begin
                fir_in_data[i_x*SAMPLE_W +: SAMPLE_W] <=
                    conv_data[acid_src(i_x[1:0], src_code_q[i_x])*SAMPLE_W +: SAMPLE_W];
            end
        end
    end

    // =========================================================
    // Delay lines, tap 0 newest; shift runs always so a change settles fast
    // Taps keep shifting while disabled, so enabling finds a full history
    // 16-tap line
    always @(posedge clk_sys) begin
        if (!nrst) begin
            for (j_t = 0; j_t < 4*`ACID_DELAY_TAPS; j_t = j_t + 1) begin
                tap_q[j_t] <= {SAMPLE_W{1'b0}};
            end
        end else begin
            for (i_t = 0; i_t < 4; i_t = i_t + 1) begin
                tap_q[i_t*`ACID_DELAY_TAPS] <= fir_data[i_t*SAMPLE_W +: SAMPLE_W];
                for (j_t = 1; j_t < `ACID_DELAY_TAPS; j_t = j_t + 1) begin
                    tap_q[i_t*`ACID_DELAY_TAPS + j_t] <= tap_q[i_t*`ACID_DELAY_TAPS + j_t - 1];
                end
            end
        end
    end

    // =========================================================
    // Tap selection per lane feeding the delay route
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            wire [1:0] act_prof = prof_ctrl_q[g][`ACID_CTRL_PIN_EN_BIT] ? pin_sel_q :
                                  prof_ctrl_q[g][`ACID_CTRL_SEL_MSB:`ACID_CTRL_SEL_LSB];
            wire [3:0] shift_v = profile_q[4*g + act_prof];
            assign del_flat[g*SAMPLE_W +: SAMPLE_W] = delay_en_q[g] ? tap_q[g*`ACID_DELAY_TAPS + shift_v] :
                                                                      tap_q[g*`ACID_DELAY_TAPS];
        end
    endgenerate

    // =========================================================
    // Output route
    // Route is global; a route write steers all four lanes from the next sample
    always @(posedge clk_sys) begin
        if (!nrst) begin
            path_out_data <= {4*SAMPLE_W{1'b0}};
        end else begin
            for (i_o = 0; i_o < 4; i_o = i_o + 1) begin
                case (route_q)
                    `ACID_ROUTE_FILTER: path_out_data[i_o*SAMPLE_W +: SAMPLE_W] <=
                        fir_data[i_o*SAMPLE_W +: SAMPLE_W];
                    `ACID_ROUTE_DELAY:  path_out_data[i_o*SAMPLE_W +: SAMPLE_W] <=
                        del_flat[i_o*SAMPLE_W +: SAMPLE_W];
                    default:            path_out_data[i_o*SAMPLE_W +: SAMPLE_W] <=
                        fir_in_data[i_o*SAMPLE_W +: SAMPLE_W];
                endcase
            end
        end
    end

endmodule // acid_top

// [acid_fir_model.sv]
// Purpose: Stand-in for the FIR that sits behind fir_in_data
// Assumes: Zero latency, output is the inverted input
// Notes:   Inversion keeps the filter route apart from bypass
`timescale 1ns/100ps

module acid_fir_model #(
    parameter SAMPLE_W = 16                      // Sample width
) (
    input  wire [4*SAMPLE_W-1:0] fir_in_data,    // Logical lanes in
    output wire [4*SAMPLE_W-1:0] fir_data        // Filtered lanes out
);
    // Inverting filter
    assign fir_data = ~fir_in_data;
endmodule // acid_fir_model

// [acid_chk.sv]
// Purpose: Port checker for acid_top
// Assumes: Route codes and addresses from acid_defs.vh
// Notes:   Bound to every acid_top
`timescale 1ns/100ps
`include "acid_defs.vh"

module acid_chk #(
    parameter SAMPLE_W = 16                      // Sample width
) (
    input wire                  clk_sys,         // Clock
    input wire                  nrst,            // Reset
    input wire [4*SAMPLE_W-1:0] fir_data,        // FIR return
    input wire [11:0]           reg_addr,        // Address
    input wire [7:0]            reg_wdata,       // Write data
    input wire                  reg_wr,          // Write
    input wire                  reg_rd,          // Read
    input wire [7:0]            reg_rdata,       // Read data
    input wire [4*SAMPLE_W-1:0] fir_in_data,     // Crossbar out
    input wire [4*SAMPLE_W-1:0] path_out_data    // Path out
);
    logic [1:0] route_q;
    wire        rt_wr = reg_wr && reg_addr == `ACID_ADDR_AUX_ROUTE;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========================================
    // Route shadow
    always @(posedge clk_sys) begin
        if (!nrst) route_q <= 2'h0;
        else if (rt_wr) route_q <= reg_wdata[1:0];
    end
    // ==========================================
    // Assertions
    a_rst_rdata: assert property (disable iff (1'b0) !nrst |=> reg_rdata == 8'h00)
        else $error("read data not cleared");
    a_rst_lanes: assert property (disable iff (1'b0) !nrst |=> fir_in_data == 0)
        else $error("crossbar out not cleared");
    a_rst_path: assert property (disable iff (1'b0) !nrst |=> path_out_data == 0)
        else $error("path out not cleared");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 12'h123 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_enable_back: assert property (reg_wr && reg_addr == `ACID_ADDR_DELAY_ENABLE ##1
        reg_rd && reg_addr == `ACID_ADDR_DELAY_ENABLE |=> reg_rdata[0] == $past(reg_wdata[0], 2))
        else $error("enable readback wrong");
    a_bypass_pass: assert property (route_q == 2'h0 && !rt_wr |=> path_out_data == $past(fir_in_data))
        else $error("bypass path wrong");
    a_filter_pass: assert property (route_q == 2'h1 && !rt_wr |=> path_out_data == $past(fir_data))
        else $error("filter path wrong");
    c_filter: cover property (route_q == 2'h1);
    c_delay: cover property (route_q == 2'h2);
    c_pin: cover property (reg_wr && reg_addr == `ACID_ADDR_PROFILE_CTRL && reg_wdata[4]);
endmodule // acid_chk

bind acid_top acid_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
    .fir_data(fir_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fir_in_data(fir_in_data), .path_out_data(path_out_data));

// [testbench.sv]
// Purpose: Self-checking bench for acid_top
// Assumes: Four- and two-converter instances, 16-bit samples, FIR model inverts
// Notes:   Expected values queued by the driver, popped by the monitor
`timescale 1ns/100ps
`include "acid_defs.vh"

module testbench;
    logic        clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, chk_req = 1'b0, inv = 1'b0;
    logic [63:0] conv_data = 64'h0, fir_data, fir_in_data, fir_in_data2, path_out_data;
    logic [127:0] e, s, x, q_v[$], hist[$];
    string       nm;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic [1:0]  delay_pin_sel = 2'h0, code[4];
    logic [3:0]  prof[4];
    int          q_k[$], lg[4], t4[16] = '{0,2,1,3,2,1,3,0,1,3,0,2,3,0,2,1};
    int          t2[16] = '{0,0,1,1,1,1,0,0,1,1,0,0,0,0,1,1};
    int          n_mismatch = 0, compares = 0, cyc_n = 0, i, k;
    acid_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .conv_data(conv_data), .fir_data(fir_data),
        .delay_pin_sel(delay_pin_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fir_in_data(fir_in_data), .path_out_data(path_out_data));
    acid_fir_model u_fir (.fir_in_data(fir_in_data), .fir_data(fir_data));
    // Two-converter variant sees the same register traffic and samples
    acid_top #(.NUM_CONV(2)) u_dut2 (.clk_sys(clk_sys), .nrst(nrst), .conv_data(conv_data), .fir_data(fir_data),
        .delay_pin_sel(delay_pin_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(), .fir_in_data(fir_in_data2), .path_out_data());
    // Clock
    always #5 clk_sys = ~clk_sys;
    // Crossbar prediction, four-converter lanes low, two-converter lanes high
    function automatic logic [127:0] xb(input logic [63:0] c);
        for (int l = 0; l < 4; l++) begin
            xb[l*16+:16] = c[t4[l*4+code[l]]*16+:16];
            xb[64+l*16+:16] = c[t2[l*4+code[l]]*16+:16];
        end
    endfunction
    // One cycle of stimulus
    task automatic step(input logic w = 0, r = 0, c = 0);
        @(posedge clk_sys);
        #1;
        reg_wr = w;
        reg_rd = r;
        chk_req = c;
        conv_data = {$urandom, $urandom};
        hist.push_front(xb(conv_data));
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        step(1, 0, 0);
        reg_addr = a;
        reg_wdata = d;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        step(0, 1, 0);
        reg_addr = a;
        q_k.push_back(0);
        q_v.push_back({120'h0, d});
    endtask
    task automatic src(input logic [1:0] a, b, c, d);
        wr(`ACID_ADDR_FILT_PAGE, 8'h01);
        wr(`ACID_ADDR_SRC_SELECT, {4'h0, b, a});
        wr(`ACID_ADDR_FILT_PAGE, 8'h02);
        wr(`ACID_ADDR_SRC_SELECT, {4'h0, d, c});
        code = '{a, b, c, d};
    endtask
    // Settle, then queue eight lane checks of kind m
    task automatic chk(input int m);
        repeat (20) step();
        repeat (8) begin
            step(0, 0, 1);
            for (int l = 0; l < 4; l++)
                e[l*16+:16] = (m == 1) ? hist[0][l*16+:16] : hist[lg[l]][l*16+:16] ^ {16{inv}};
            e[127:64] = (m == 1) ? hist[0][127:64] : 64'h0;
            q_k.push_back(m);
            q_v.push_back(e);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Monitor pops the oldest note per result
    always @(posedge clk_sys) begin
        if (reg_rd === 1'b1 || chk_req === 1'b1) begin
            #2;
            k = q_k.pop_front();
            x = q_v.pop_front();
            nm = (k == 0) ? "reg_rdata" : (k == 1) ? "fir_in_data" : "path_out_data";
            s = (k == 0) ? {120'h0, reg_rdata} : (k == 1) ? {fir_in_data2, fir_in_data} : {64'h0, path_out_data};
            compares++;
            if (s !== x) begin
                n_mismatch++;
                $display("unexpected %s expected %h got %h", nm, x, s);
            end
        end
    end
    // Timeout
    always @(posedge clk_sys) begin
        cyc_n++;
        if (cyc_n == 4000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(31889));
        code = '{0, 0, 0, 0};
        repeat (3) @(posedge clk_sys);
        #1 nrst = 1'b1;
        rd(`ACID_ADDR_PROFILE_0, 8'h08);
        wr(12'h123, 8'h5A);
        rd(12'h123, 8'h00);
        for (i = 0; i < 16; i++) begin
            src(i[1:0], i[3:2], i[3:2], i[1:0]);
            rd(`ACID_ADDR_SRC_SELECT, {4'h0, i[1:0], i[3:2]});
            chk(1);
        end
        $display("test crossbar done");
        lg = '{1, 1, 1, 1};
        chk(2);
        wr(`ACID_ADDR_AUX_ROUTE, 8'h01);
        inv = 1'b1;
        chk(2);
        wr(`ACID_ADDR_AUX_ROUTE, 8'h02);
        lg = '{2, 2, 2, 2};
        chk(2);
        $display("test route done");
        wr(`ACID_ADDR_COARSE_PAGE, 8'h0F);
        wr(`ACID_ADDR_DELAY_ENABLE, 8'h01);
        rd(`ACID_ADDR_DELAY_ENABLE, 8'h01);
        prof = '{4'h0, 4'hF, 4'($urandom), 4'($urandom)};
        for (i = 0; i < 4; i++) wr(`ACID_ADDR_PROFILE_0 + 12'(i), {4'h0, prof[i]});
        rd(`ACID_ADDR_PROFILE_3, {4'h0, prof[3]});
        for (i = 0; i < 4; i++) begin
            wr(`ACID_ADDR_PROFILE_CTRL, 8'(i));
            lg = '{2 + prof[i], 2 + prof[i], 2 + prof[i], 2 + prof[i]};
            chk(2);
        end
        wr(`ACID_ADDR_PROFILE_CTRL, 8'h13);
        for (i = 0; i < 4; i++) begin
            delay_pin_sel = 2'(i);
            lg = '{2 + prof[i], 2 + prof[i], 2 + prof[i], 2 + prof[i]};
            chk(2);
        end
        wr(`ACID_ADDR_PROFILE_CTRL, 8'h00);
        wr(`ACID_ADDR_COARSE_PAGE, 8'h01);
        wr(`ACID_ADDR_PROFILE_0, 8'h07);
        lg = '{9, 2, 2, 2};
        chk(2);
        $display("test delay done");
        @(posedge clk_sys);
        #1 nrst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 nrst = 1'b1;
        rd(`ACID_ADDR_DELAY_ENABLE, 8'h00);
        step();
        step();
        $display("test reset done");
        end_sim();
    end
endmodule // testbench
